/* File: rtl/dic_defs.svh */
// Summary of operation
// - debug control bit 31 picks register values over debug control unit; resets 0
// - debug bits 3..0 drive the four debug enables; bits 3..1 reset 1, bit 0 resets 0
// - interrupt control bit 17 inverts the synchronised external pin level before the enable; resets 0
// - interrupt control bit 16 enables the external interrupt pin; resets 0
// - interrupt control bit 5 clears the ram protection interrupt; resets 0
// - interrupt control bit 4 enables the ram protection interrupt; resets 0
// - interrupt control bit 3 clears the flash protection interrupt; resets 0
// - interrupt control bit 2 enables the flash protection interrupt; resets 0
// - interrupt control bit 1 clears the peripheral protection interrupt; resets 1
// - interrupt control bit 0 enables the peripheral protection interrupt; resets 0
// - core 0 boot vector in bits 31..7, low bits reserved, printed reset
// - core 1 boot vector in bits 31..7, low bits reserved, printed reset
// - per pin input goes to main function when 1, alternate one when 0
// - per pin output data from main function when 1, alternate one when 0
// - per pin output enable from main function when 1, alternate one when 0
`ifndef DIC_DEFS_SVH
`define DIC_DEFS_SVH
// register byte offsets
`define DIC_OFS_DBG 6'h00
`define DIC_OFS_ICTL 6'h04
`define DIC_OFS_VEC0 6'h08
`define DIC_OFS_VEC1 6'h0c
`define DIC_OFS_INSEL 6'h10
`define DIC_OFS_OUTSEL 6'h14
`define DIC_OFS_OESEL 6'h18
`define DIC_OFS_STS 6'h1c
`define DIC_OFS_MSK 6'h20
// writable masks and reset values
`define DIC_DBG_MASK 32'h8000_07df
`define DIC_DBG_RST 32'h0000_001e
`define DIC_ICTL_MASK 32'h0003_003f
`define DIC_ICTL_RST 32'h0000_0002
`define DIC_VEC_MASK 32'hffff_ff80
`define DIC_VEC_RST 32'h0000_4000
`define DIC_SEL_MASK 32'h0000_ffff
`define DIC_SEL_RST 32'h0000_ffff
`define DIC_EVT_MASK 32'h0000_000f
// debug control fields
`define DIC_DBG_OVR 31
`define DIC_DBG_SE 10
`define DIC_DBG_DIS 9
`define DIC_DBG_BYP 8
`define DIC_DBG_FRQ 7:6
`define DIC_DBG_LLG 4
`define DIC_DBG_SNI 3
`define DIC_DBG_SI 2
`define DIC_DBG_NI 1
`define DIC_DBG_INV 0
// interrupt control fields
`define DIC_IC_INVERT 17
`define DIC_IC_EXT_EN 16
`define DIC_IC_RAM_CLR 5
`define DIC_IC_RAM_EN 4
`define DIC_IC_FLS_CLR 3
`define DIC_IC_FLS_EN 2
`define DIC_IC_PER_CLR 1
`define DIC_IC_PER_EN 0
// event status bits
`define DIC_EV_EXT 0
`define DIC_EV_PER 1
`define DIC_EV_FLS 2
`define DIC_EV_RAM 3
// ahb transfer type bit that marks an active transfer
`define DIC_HTRANS_ACT 1
`endif

/* File: rtl/dic_pkg.sv */
`include "dic_defs.svh"
package dic_pkg;
    // whole state of the register bank
    typedef struct packed {
        logic ph_wr;
        logic ph_rd;
        logic [5:0] ph_addr;
        logic [31:0] hrdata;
        logic [31:0] dbg;
        logic [31:0] ictl;
        logic [31:0] vec0;
        logic [31:0] vec1;
        logic [31:0] insel;
        logic [31:0] outsel;
        logic [31:0] oesel;
        logic [3:0] sts;
        logic [3:0] msk;
        logic pin_s1;
        logic pin_s2;
        logic [15:0] gpio_s1;
        logic [15:0] gpio_s2;
        logic [15:0] main_in;
        logic [15:0] alt_in;
        logic [15:0] gpio_out;
        logic [15:0] gpio_oe;
        logic ext_irq;
    } dic_state_t;
endpackage

/* File: rtl/dic_regs.sv */
`timescale 1ns/1ps
`include "dic_defs.svh"
module dic_regs #(
    parameter int PINS = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    // debug control unit values, used unless overridden
    input wire logic dcu_secure_noninvasive_debug_en,
    input wire logic dcu_secure_invasive_debug_en,
    input wire logic dcu_noninvasive_debug_en,
    input wire logic dcu_invasive_debug_en,
    input wire logic dcu_lowlevel_debug_gen_ctl,
    output logic secure_noninvasive_debug_en,
    output logic secure_invasive_debug_en,
    output logic noninvasive_debug_en,
    output logic invasive_debug_en,
    output logic lowlevel_debug_gen_ctl,
    output logic chip_security_se_ctl,
    output logic chip_security_discharge_ctl,
    output logic chip_security_bypass,
    output logic [1:0] chip_security_freq_select,
    // external interrupt pin, asynchronous
    input wire logic external_irq_pin,
    output logic external_irq,
    // protection controller interrupts
    input wire logic periph_protect_irq,
    input wire logic flash_protect_irq,
    input wire logic ram_protect_irq,
    output logic periph_protect_irq_enable,
    output logic periph_protect_irq_clear,
    output logic flash_protect_irq_enable,
    output logic flash_protect_irq_clear,
    output logic ram_protect_irq_enable,
    output logic ram_protect_irq_clear,
    // core boot vectors
    output logic [31:0] core0_boot_vector,
    output logic [31:0] core1_boot_vector,
    // pin multiplexer
    input wire logic [PINS-1:0] gpio_in,
    output logic [PINS-1:0] gpio_out,
    output logic [PINS-1:0] gpio_oe,
    output logic [PINS-1:0] main_func_in,
    output logic [PINS-1:0] alternate_function_one_in,
    input wire logic [PINS-1:0] main_func_out,
    input wire logic [PINS-1:0] main_func_oe,
    input wire logic [PINS-1:0] alternate_function_one_out,
    input wire logic [PINS-1:0] alternate_function_one_oe
);

    dic_pkg::dic_state_t r;
    dic_pkg::dic_state_t n;

    logic [PINS-1:0] mux_main_in;
    logic [PINS-1:0] mux_alt_in;
    logic [PINS-1:0] mux_out;
    logic [PINS-1:0] mux_oe;
    logic ext_level;
    logic [3:0] events;
    logic [31:0] wmask;

    // per pin routing, each bit from its own select
    genvar gi;
    generate
        for (gi = 0; gi < PINS; gi = gi + 1) begin : g_pin
            // unselected side sees zero so it never floats
            assign mux_main_in[gi] = r.insel[gi] & r.gpio_s2[gi];
            assign mux_alt_in[gi] = ~r.insel[gi] & r.gpio_s2[gi];
            assign mux_out[gi] = r.outsel[gi] ? main_func_out[gi] :
                alternate_function_one_out[gi];
            assign mux_oe[gi] = r.oesel[gi] ? main_func_oe[gi] :
                alternate_function_one_oe[gi];
        end
    endgenerate

    // combined external interrupt: optional inversion of the pin, then enable
    assign ext_level = r.ictl[`DIC_IC_EXT_EN] &
        (r.pin_s2 ^ r.ictl[`DIC_IC_INVERT]);

    // event sources for the sticky status bits
    always_comb begin
        events = 4'h0;
        events[`DIC_EV_EXT] = r.ext_irq;
        events[`DIC_EV_PER] = periph_protect_irq;
        events[`DIC_EV_FLS] = flash_protect_irq;
        events[`DIC_EV_RAM] = ram_protect_irq;
    end

    // next state: sync chains, bus decode, register writes, read data
    always_comb begin
        n = r;
        wmask = 32'h0;

        // two flops on everything from the pins
        n.pin_s1 = external_irq_pin;
        n.pin_s2 = r.pin_s1;
        n.gpio_s1 = gpio_in;
        n.gpio_s2 = r.gpio_s1;

        // registered pin-side data
        n.main_in = mux_main_in;
        n.alt_in = mux_alt_in;
        n.gpio_out = mux_out;
        n.gpio_oe = mux_oe;
        n.ext_irq = ext_level;

        // sticky status; a new event beats a same-cycle clear
        n.sts = r.sts | events;

        // data phase of a write
        if (r.ph_wr) begin
            case (r.ph_addr)
                `DIC_OFS_DBG: begin
                    wmask = `DIC_DBG_MASK;
                    n.dbg = hwdata & wmask;
                end
                `DIC_OFS_ICTL: begin
                    wmask = `DIC_ICTL_MASK;
                    n.ictl = hwdata & wmask;
                end
                `DIC_OFS_VEC0: begin
                    wmask = `DIC_VEC_MASK;
                    n.vec0 = hwdata & wmask;
                end
                `DIC_OFS_VEC1: begin
                    wmask = `DIC_VEC_MASK;
                    n.vec1 = hwdata & wmask;
                end
                `DIC_OFS_INSEL: begin
                    wmask = `DIC_SEL_MASK;
                    n.insel = hwdata & wmask;
                end
                `DIC_OFS_OUTSEL: begin
                    wmask = `DIC_SEL_MASK;
                    n.outsel = hwdata & wmask;
                end
                `DIC_OFS_OESEL: begin
                    wmask = `DIC_SEL_MASK;
                    n.oesel = hwdata & wmask;
                end
                `DIC_OFS_STS: begin
                    // write one to clear, events still win
                    n.sts = (r.sts & ~hwdata[3:0]) | events;
                end
                `DIC_OFS_MSK: begin
                    n.msk = hwdata[3:0];
                end
                default: begin
                    // unmapped writes are dropped
                    wmask = 32'h0;
                end
            endcase
        end

        // address phase; only sampled while the bus is ready
        if (hready) begin
            n.ph_wr = hsel & htrans[`DIC_HTRANS_ACT] & hwrite;
            n.ph_rd = hsel & htrans[`DIC_HTRANS_ACT] & ~hwrite;
            n.ph_addr = {haddr[5:2], 2'b00};
        end

        // read data is taken from post-write values so a read
        // right after a write to the same word sees the new data
        n.hrdata = 32'h0;
        if (hready && hsel && htrans[`DIC_HTRANS_ACT] && !hwrite) begin
            case ({haddr[5:2], 2'b00})
                `DIC_OFS_DBG: begin
                    n.hrdata = n.dbg;
                end
                `DIC_OFS_ICTL: begin
                    n.hrdata = n.ictl;
                end
                `DIC_OFS_VEC0: begin
                    n.hrdata = n.vec0;
                end
                `DIC_OFS_VEC1: begin
                    n.hrdata = n.vec1;
                end
                `DIC_OFS_INSEL: begin
                    n.hrdata = n.insel;
                end
                `DIC_OFS_OUTSEL: begin
                    n.hrdata = n.outsel;
                end
                `DIC_OFS_OESEL: begin
                    n.hrdata = n.oesel;
                end
                `DIC_OFS_STS: begin
                    n.hrdata = {28'h0, n.sts};
                end
                `DIC_OFS_MSK: begin
                    n.hrdata = {28'h0, n.msk};
                end
                default: begin
                    // unmapped and upper-window reads give zero
                    n.hrdata = 32'h0;
                end
            endcase
            // read addresses above the map alias nothing; writes decode only haddr[5:2]
            if (haddr[31:6] != 26'h0) begin
                n.hrdata = 32'h0;
            end
        end
        if (r.ph_wr && (r.ph_addr > `DIC_OFS_MSK)) begin
            n.dbg = r.dbg;
        end
    end

    // single state register, constants only under reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r <= '0;
            r.dbg <= `DIC_DBG_RST;
            r.ictl <= `DIC_ICTL_RST;
            r.vec0 <= `DIC_VEC_RST;
            r.vec1 <= `DIC_VEC_RST;
            r.insel <= `DIC_SEL_RST;
            r.outsel <= `DIC_SEL_RST;
            r.oesel <= `DIC_SEL_RST;
        end else begin
            r <= n;
        end
    end

    // zero-wait slave, always okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = r.hrdata;

    // level interrupt while any unmasked status bit stands
    assign irq = |(r.sts & r.msk);

    // debug enables: own bits only when the override is set
    assign secure_noninvasive_debug_en = r.dbg[`DIC_DBG_OVR] ?
        r.dbg[`DIC_DBG_SNI] : dcu_secure_noninvasive_debug_en;
    assign secure_invasive_debug_en = r.dbg[`DIC_DBG_OVR] ?
        r.dbg[`DIC_DBG_SI] : dcu_secure_invasive_debug_en;
    assign noninvasive_debug_en = r.dbg[`DIC_DBG_OVR] ?
        r.dbg[`DIC_DBG_NI] : dcu_noninvasive_debug_en;
    assign invasive_debug_en = r.dbg[`DIC_DBG_OVR] ?
        r.dbg[`DIC_DBG_INV] : dcu_invasive_debug_en;
    assign lowlevel_debug_gen_ctl = r.dbg[`DIC_DBG_OVR] ?
        r.dbg[`DIC_DBG_LLG] : dcu_lowlevel_debug_gen_ctl;

    // security controls are plain stored outputs
    assign chip_security_se_ctl = r.dbg[`DIC_DBG_SE];
    assign chip_security_discharge_ctl = r.dbg[`DIC_DBG_DIS];
    assign chip_security_bypass = r.dbg[`DIC_DBG_BYP];
    assign chip_security_freq_select = r.dbg[`DIC_DBG_FRQ];

    // external interrupt is registered after the sync chain
    assign external_irq = r.ext_irq;

    // protection controller enables and level clears
    assign periph_protect_irq_enable = r.ictl[`DIC_IC_PER_EN];
    assign periph_protect_irq_clear = r.ictl[`DIC_IC_PER_CLR];
    assign flash_protect_irq_enable = r.ictl[`DIC_IC_FLS_EN];
    assign flash_protect_irq_clear = r.ictl[`DIC_IC_FLS_CLR];
    assign ram_protect_irq_enable = r.ictl[`DIC_IC_RAM_EN];
    assign ram_protect_irq_clear = r.ictl[`DIC_IC_RAM_CLR];

    // boot vectors, reserved low bits always zero
    assign core0_boot_vector = r.vec0;
    assign core1_boot_vector = r.vec1;

    // pin side, one cycle behind the select and function side, three behind gpio_in
    assign gpio_out = r.gpio_out;
    assign gpio_oe = r.gpio_oe;
    assign main_func_in = r.main_in;
    assign alternate_function_one_in = r.alt_in;

endmodule

/* File: bench/dic_regs_checker.sv */
`timescale 1ns/1ps
`include "dic_defs.svh"
module dic_regs_checker #(
    parameter int PINS = 16
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic dcu_invasive_debug_en,
    input wire logic invasive_debug_en,
    input wire logic periph_protect_irq_enable,
    input wire logic periph_protect_irq_clear,
    input wire logic [31:0] core0_boot_vector,
    input wire logic [PINS-1:0] gpio_in,
    input wire logic [PINS-1:0] gpio_out,
    input wire logic [PINS-1:0] gpio_oe,
    input wire logic [PINS-1:0] main_func_in,
    input wire logic [PINS-1:0] alternate_function_one_in,
    input wire logic [PINS-1:0] main_func_out,
    input wire logic [PINS-1:0] main_func_oe,
    input wire logic [PINS-1:0] alternate_function_one_out,
    input wire logic [PINS-1:0] alternate_function_one_oe
);
    logic [1:0] age;
    // edges since release; the input route needs three before it is meaningful
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            age <= 2'h0;
        end else if (age != 2'h3) begin
            age <= age + 2'h1;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // address phase of a write to one word, then its data phase
    sequence s_wr(logic [5:0] ofs);
        hsel && htrans[1] && hwrite && hready && {haddr[5:2], 2'b00} == ofs ##1 1'b1;
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus stalled or erred");
    a_rdata_idle: assert property (!(hsel && htrans[1] && !hwrite && hready) |=> hrdata == 32'h0)
        else $error("read data without a read");
    a_vec_low: assert property (core0_boot_vector[6:0] == 7'h0) else $error("vector low bits");
    a_vec_write: assert property (s_wr(`DIC_OFS_VEC0) |=>
        core0_boot_vector == ($past(hwdata) & 32'hffff_ff80)) else $error("vector write");
    a_ctl_write: assert property (s_wr(`DIC_OFS_ICTL) |=> {periph_protect_irq_clear,
        periph_protect_irq_enable} == $past(hwdata[1:0])) else $error("irq ctl");
    a_dbg_forced: assert property (s_wr(`DIC_OFS_DBG) ##0 hwdata[31] |=>
        invasive_debug_en == $past(hwdata[0])) else $error("debug forced");
    a_dbg_follow: assert property (s_wr(`DIC_OFS_DBG) ##0 !hwdata[31] |=>
        invasive_debug_en == dcu_invasive_debug_en) else $error("debug follow");
    a_out_route: assert property (main_func_out == alternate_function_one_out |=>
        gpio_out == $past(main_func_out)) else $error("output route");
    a_oe_route: assert property (main_func_oe == alternate_function_one_oe |=>
        gpio_oe == $past(main_func_oe)) else $error("enable route");
    a_in_route: assert property (age == 2'h3 |-> (main_func_in | alternate_function_one_in)
        == $past(gpio_in, 3) && (main_func_in & alternate_function_one_in) == '0)
        else $error("input route");
endmodule
bind dic_regs dic_regs_checker #(.PINS(PINS)) u_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .dcu_invasive_debug_en(dcu_invasive_debug_en),
    .invasive_debug_en(invasive_debug_en),
    .periph_protect_irq_enable(periph_protect_irq_enable),
    .periph_protect_irq_clear(periph_protect_irq_clear),
    .core0_boot_vector(core0_boot_vector), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .main_func_in(main_func_in),
    .alternate_function_one_in(alternate_function_one_in), .main_func_out(main_func_out),
    .main_func_oe(main_func_oe), .alternate_function_one_out(alternate_function_one_out),
    .alternate_function_one_oe(alternate_function_one_oe));

/* File: bench/testbench.sv */
`timescale 1ns/1ps
module testbench;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, pin = 1'b0;
    logic hready, hreadyout, hresp, irq, ext_irq;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, vec0, vec1, q, r;
    logic [1:0] htrans = 2'h0;
    logic [4:0] debug_control_unit = 5'h0, dbg_out, sec;
    logic [5:0] ctl;
    logic [3:1] src = 3'h0;
    logic [15:0] gin = 16'h0, mout = 16'h0, moe = 16'h0, aout = 16'h0, aoe = 16'h0;
    logic [15:0] gout, goe, min, ain;
    logic [31:0] v [7];
    int err_count = 0, num_checks = 0;
    localparam logic [31:0] MASK [7] = '{32'h8000_07df, 32'h0003_003f, 32'hffff_ff80,
        32'hffff_ff80, 32'h0000_ffff, 32'h0000_ffff, 32'h0000_ffff};
    localparam logic [31:0] RST [10] = '{32'h1e, 32'h2, 32'h4000, 32'h4000, 32'hffff,
        32'hffff, 32'hffff, 32'h0, 32'h0, 32'h0};
    assign hready = hreadyout; // the only slave drives the bus ready
    dic_regs u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hready), .hwdata(hwdata),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .dcu_secure_noninvasive_debug_en(debug_control_unit[3]), .dcu_secure_invasive_debug_en(debug_control_unit[2]),
        .dcu_noninvasive_debug_en(debug_control_unit[1]), .dcu_invasive_debug_en(debug_control_unit[0]),
        .dcu_lowlevel_debug_gen_ctl(debug_control_unit[4]), .secure_noninvasive_debug_en(dbg_out[3]),
        .secure_invasive_debug_en(dbg_out[2]), .noninvasive_debug_en(dbg_out[1]),
        .invasive_debug_en(dbg_out[0]), .lowlevel_debug_gen_ctl(dbg_out[4]),
        .chip_security_se_ctl(sec[4]), .chip_security_discharge_ctl(sec[3]),
        .chip_security_bypass(sec[2]), .chip_security_freq_select(sec[1:0]),
        .external_irq_pin(pin), .external_irq(ext_irq), .periph_protect_irq(src[1]),
        .flash_protect_irq(src[2]), .ram_protect_irq(src[3]),
        .periph_protect_irq_enable(ctl[0]), .periph_protect_irq_clear(ctl[1]),
        .flash_protect_irq_enable(ctl[2]), .flash_protect_irq_clear(ctl[3]),
        .ram_protect_irq_enable(ctl[4]), .ram_protect_irq_clear(ctl[5]),
        .core0_boot_vector(vec0), .core1_boot_vector(vec1), .gpio_in(gin), .gpio_out(gout),
        .gpio_oe(goe), .main_func_in(min), .alternate_function_one_in(ain),
        .main_func_out(mout), .main_func_oe(moe), .alternate_function_one_out(aout),
        .alternate_function_one_oe(aoe));
    // free running bus clock
    initial begin
        forever #5 hclk = ~hclk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // wait for the edge at which ready is sampled high; the watchdog ends a hang
    task automatic wait_rdy;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            @(posedge hclk);
        end
    endtask
    // expected pin route: main side where the select bit is one
    function automatic logic [15:0] route(input logic [15:0] sel, input logic [15:0] m,
        input logic [15:0] a);
        return (m & sel) | (a & ~sel);
    endfunction
    // one single word transfer; read data lands in q
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic report_and_stop;
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles the sequence needs
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
    initial begin
        void'($urandom(61510));
        debug_control_unit = 5'h15;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk({dbg_out, ctl}, {debug_control_unit, 6'h02});
        for (int i = 0; i < 10; i++) rd(i * 4, RST[i]);
        // all ones first, then random words, through the seven control and select registers
        for (int k = 0; k < 3; k++) begin
            for (int i = 0; i < 7; i++) begin
                v[i] = (k == 0) ? 32'hffff_ffff : $urandom;
                bus(1'b1, i * 4, v[i]);
            end
            for (int i = 0; i < 7; i++) rd(i * 4, v[i] & MASK[i]);
            r = $urandom;
            debug_control_unit <= r[4:0];
            gin <= r[31:16];
            mout <= r[15:0];
            aout <= (k == 2) ? r[15:0] : r[31:16];
            moe <= ~r[15:0];
            aoe <= (k == 2) ? ~r[15:0] : r[23:8];
            repeat (4) @(posedge hclk);
            chk(dbg_out, v[0][31] ? v[0][4:0] : debug_control_unit);
            chk(sec, v[0][10:6]);
            chk(ctl, v[1][5:0]);
            chk(vec0, v[2] & MASK[2]);
            chk(vec1, v[3] & MASK[3]);
            chk({min, ain}, {route(v[4][15:0], gin, 16'h0), route(v[4][15:0], 16'h0, gin)});
            chk(gout, route(v[5][15:0], mout, aout));
            chk(goe, route(v[6][15:0], moe, aoe));
        end
        // every enable, polarity and pin level combination
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 32'h4, {c[1:0], 16'h0});
            pin <= c[2];
            repeat (4) @(posedge hclk);
            chk(ext_irq, c[0] & (c[2] ^ c[1]));
        end
        bus(1'b1, 32'h4, 32'h0);
        bus(1'b1, 32'h1c, 32'hf);
        // sticky event, masked, unmasked, then cleared by writing one
        for (int b = 1; b < 4; b++) begin
            src <= 3'h1 << (b - 1);
            @(posedge hclk);
            src <= 3'h0;
            bus(1'b1, 32'h1c, 32'hf ^ (32'h1 << b));
            rd(32'h1c, 32'h1 << b);
            chk(irq, 1'b0);
            bus(1'b1, 32'h20, 32'h1 << b);
            @(posedge hclk);
            chk(irq, 1'b1);
            bus(1'b1, 32'h1c, 32'h1 << b);
            @(posedge hclk);
            chk(irq, 1'b0);
            rd(32'h1c, 32'h0);
            bus(1'b1, 32'h20, 32'h0);
        end
        // an event still standing beats a same-cycle write-one clear
        src <= 3'h1;
        bus(1'b1, 32'h1c, 32'h2);
        rd(32'h1c, 32'h2);
        src <= 3'h0;
        bus(1'b1, 32'h1c, 32'h2);
        rd(32'h1c, 32'h0);
        bus(1'b1, 32'h24, 32'hffff_ffff);
        rd(32'h24, 32'h0);
        rd(32'h44, 32'h0);
        report_and_stop();
    end
endmodule
